/* File: pwm_steer_pkg.sv */
// constants, register map and field layout for the bridge output steering stage
package pwm_steer_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int DUTY_W = 10;
  localparam int FINE_W = 2;
  localparam int DBAND_W = 7;
  localparam int PINS = 4;
  localparam int DCNT_W = DBAND_W + FINE_W;

  // register indices on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_DUTY   = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_DBAND  = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_STEER  = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_TBASE  = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_SHADOW = 3'h6;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h7;

  // modulator_control_register fields
  localparam int CFG_HI = 7;
  localparam int CFG_LO = 6;
  localparam int DLSB_HI = 5;
  localparam int DLSB_LO = 4;
  localparam int MSEL_HI = 3;
  localparam int MSEL_LO = 2;
  localparam int POL_AC = 1;
  localparam int POL_BD = 0;

  // output_config_field encodings
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FWD    = 2'h1;
  localparam logic [1:0] CFG_HALF   = 2'h2;
  localparam logic [1:0] CFG_REV    = 2'h3;

  // mode select value in mode_polarity_field that turns the modulator on
  localparam logic [1:0] MSEL_PWM = 2'h3;

  localparam logic [1:0] FINE_LAST = 2'h3;

  // pin index order
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;

  // reset values and pin use masks
  localparam logic [DATA_W-1:0]  RST_CTRL   = 8'h00;
  localparam logic [DATA_W-1:0]  RST_DUTY   = 8'h00;
  localparam logic [DATA_W-1:0]  RST_PERIOD = 8'hFF;
  localparam logic [DBAND_W-1:0] RST_DBAND  = 7'h00;
  localparam logic [PINS-1:0]    RST_STEER  = 4'h1;
  localparam logic [PINS-1:0]    HALF_USE   = 4'h3;
  localparam logic [PINS-1:0]    FULL_USE   = 4'hF;

endpackage

/* File: deadband_delay.sv */
// delays the active-going edge of one half-bridge output by a programmed count
`timescale 1ns/10ps
module deadband_delay
(
  input  wire logic                              clk_sys_in,
  input  wire logic                              arst_n_in,
  input  wire logic                              enable_in,
  input  wire logic                              active_in,
  input  wire logic [pwm_steer_pkg::DBAND_W-1:0] count_in,
  output logic                                   active_out
);

  typedef enum logic [1:0] {DB_IDLE, DB_WAIT, DB_ON} db_state_e;

  typedef struct packed {
    db_state_e                         st;
    logic [pwm_steer_pkg::DCNT_W-1:0]  cnt;
    logic                              out;
  } db_s;

  db_s s_r;
  db_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    case (s_r.st)
      DB_IDLE:
      begin
        s_nxt.out = 1'b0;
        if (enable_in && active_in)
        begin
          if (count_in == '0)
          begin
            s_nxt.st = DB_ON;
            s_nxt.out = 1'b1;
          end
          else
          begin
            // count is in instruction cycles, four system clocks each
            s_nxt.cnt = {count_in, {pwm_steer_pkg::FINE_W{1'b0}}};
            s_nxt.st = DB_WAIT;
          end
        end
      end
      DB_WAIT:
      begin
        // a pulse shorter than the delay never reaches the pin
        if (!enable_in || !active_in)
          s_nxt.st = DB_IDLE;
        else if (s_r.cnt == pwm_steer_pkg::DCNT_W'(1))
        begin
          s_nxt.st = DB_ON;
          s_nxt.out = 1'b1;
        end
        else
          s_nxt.cnt = s_r.cnt - pwm_steer_pkg::DCNT_W'(1);
      end
      DB_ON:
      begin
        if (!enable_in || !active_in)
        begin
          s_nxt.st = DB_IDLE;
          s_nxt.out = 1'b0;
        end
      end
      default:
      begin
        s_nxt.st = DB_IDLE;
        s_nxt.out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      s_r <= '{st: DB_IDLE, cnt: '0, out: 1'b0};
    else
      s_r <= s_nxt;
  end

  assign active_out = s_r.out;

  dband_hold_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (s_r.st == DB_IDLE && enable_in && active_in && count_in != '0) |=> !s_r.out [*4])
    else $error("dead-band delay too short");

  dband_drop_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (!active_in) |=> !s_r.out)
    else $error("delayed output active while source inactive");

endmodule

/* File: bridge_pwm_output_steering.sv */
// time base, duty buffering and four-pin output steering of the bridge modulator
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps

// Functional notes
// - config field 00 single, 10 half-bridge, 01 full forward, 11 full reverse.
// - up to four output pins, duty resolution up to ten bits.
// - mode/polarity field picks active-high or active-low outputs.
// - after enable, outputs held until a new period begins.
// - control register all zero releases all four pins.
// - pins unused by the configuration are never driven.
// - single mode drives modulated signal on each steering-enabled pin.
// - half-bridge: A modulated, B complement, C and D unused.
// - seven-bit dead-band delays active-going edge by instruction cycles.
// - dead-band longer than active time keeps that output inactive.
// - forward: A active, D modulated, B and C inactive.
// - reverse: C active, B modulated, A and D inactive.
// - at time base equal to period: clear, go active unless zero, latch duty.
// - modulated signal goes inactive when time base equals latched duty.
// - written duty is double-buffered, takes effect at period end.
module bridge_pwm_output_steering
#(
  parameter int DUTY_W = pwm_steer_pkg::DUTY_W
)
(
  input  wire logic                                clk_sys_in,
  input  wire logic                                arst_n_in,
  input  wire logic [pwm_steer_pkg::ADDR_W-1:0]    reg_addr_in,
  input  wire logic [pwm_steer_pkg::DATA_W-1:0]    reg_wdata_in,
  input  wire logic                                reg_wr_in,
  input  wire logic                                reg_rd_in,
  output logic      [pwm_steer_pkg::DATA_W-1:0]    reg_rdata_out,
  output logic                                     out_a_out,
  output logic                                     out_a_oe_out,
  output logic                                     out_b_out,
  output logic                                     out_b_oe_out,
  output logic                                     out_c_out,
  output logic                                     out_c_oe_out,
  output logic                                     out_d_out,
  output logic                                     out_d_oe_out
);

  localparam int DW = pwm_steer_pkg::DATA_W;
  localparam int NP = pwm_steer_pkg::PINS;

  typedef struct packed {
    logic [DW-1:0]                      ctrl;
    logic [DW-1:0]                      duty_hi;
    logic [DW-1:0]                      period;
    logic [pwm_steer_pkg::DBAND_W-1:0]  dband;
    logic [NP-1:0]                      steer;
    logic [DW-1:0]                      tmr;
    logic [pwm_steer_pkg::FINE_W-1:0]   fine;
    logic [DUTY_W-1:0]                  shadow;
    logic                               mod;
    logic                               started;
    logic [DW-1:0]                      rdata;
    logic [NP-1:0]                      lvl;
    logic [NP-1:0]                      oe;
  } steer_s;

  steer_s s_r;
  steer_s s_nxt;

  logic [1:0]        cfg;
  logic              pwm_on;
  logic              run;
  logic [DUTY_W-1:0] tbase;
  logic [DUTY_W-1:0] tbase_inc;
  logic [DUTY_W-1:0] duty_new;
  logic              pstart;
  logic              pol_ac;
  logic              pol_bd;
  logic              half_en;
  logic              dly_a;
  logic              dly_b;
  logic [NP-1:0]     act;
  logic [NP-1:0]     use_mask;
  logic [NP-1:0]     pol_mask;
  logic [DW-1:0]     rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // decode of control fields

  assign cfg     = s_r.ctrl[pwm_steer_pkg::CFG_HI:pwm_steer_pkg::CFG_LO];
  assign pwm_on  = s_r.ctrl[pwm_steer_pkg::MSEL_HI:pwm_steer_pkg::MSEL_LO] == pwm_steer_pkg::MSEL_PWM;
  assign pol_ac  = s_r.ctrl[pwm_steer_pkg::POL_AC];
  assign pol_bd  = s_r.ctrl[pwm_steer_pkg::POL_BD];
  assign run     = pwm_on && s_r.started;
  assign half_en = run && (cfg == pwm_steer_pkg::CFG_HALF);

  // ten-bit time base: eight-bit counter above the two-bit clock phase
  // the period compare includes the phase, so one period is four clocks per period count
  assign tbase     = {s_r.tmr, s_r.fine};
  assign tbase_inc = tbase + DUTY_W'(1);
  assign duty_new  = {s_r.duty_hi, s_r.ctrl[pwm_steer_pkg::DLSB_HI:pwm_steer_pkg::DLSB_LO]};
  assign pstart    = pwm_on && (tbase == {s_r.period, pwm_steer_pkg::FINE_LAST});

  ////////////////////////////////////////////////////////////////////////////
  // dead-band on both half-bridge outputs

  deadband_delay u_dband_a
  (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .enable_in  (half_en),
    .active_in  (s_r.mod),
    .count_in   (s_r.dband),
    .active_out (dly_a)
  );

  // B is the complement, so its own active edge is delayed too
  deadband_delay u_dband_b
  (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .enable_in  (half_en),
    .active_in  (!s_r.mod),
    .count_in   (s_r.dband),
    .active_out (dly_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // steering per configuration
  // pins outside use_mask keep their enable low, so the port logic keeps them

  always_comb
  begin
    act = '0;
    use_mask = '0;
    case (cfg)
      pwm_steer_pkg::CFG_SINGLE:
      begin
        act = {NP{s_r.mod}};
        use_mask = s_r.steer;
      end
      pwm_steer_pkg::CFG_HALF:
      begin
        act[pwm_steer_pkg::PIN_A] = dly_a;
        act[pwm_steer_pkg::PIN_B] = dly_b;
        use_mask = pwm_steer_pkg::HALF_USE;
      end
      pwm_steer_pkg::CFG_FWD:
      begin
        act[pwm_steer_pkg::PIN_A] = 1'b1;
        act[pwm_steer_pkg::PIN_D] = s_r.mod;
        use_mask = pwm_steer_pkg::FULL_USE;
      end
      pwm_steer_pkg::CFG_REV:
      begin
        act[pwm_steer_pkg::PIN_C] = 1'b1;
        act[pwm_steer_pkg::PIN_B] = s_r.mod;
        use_mask = pwm_steer_pkg::FULL_USE;
      end
      default:
      begin
        act = '0;
        use_mask = '0;
      end
    endcase
  end

  // A/C pair and B/D pair each carry their own polarity bit
  assign pol_mask = {pol_bd, pol_ac, pol_bd, pol_ac};

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb
  begin
    rd_val = '0;
    case (reg_addr_in)
      pwm_steer_pkg::ADDR_CTRL:   rd_val = s_r.ctrl;
      pwm_steer_pkg::ADDR_DUTY:   rd_val = s_r.duty_hi;
      pwm_steer_pkg::ADDR_PERIOD: rd_val = s_r.period;
      pwm_steer_pkg::ADDR_DBAND:  rd_val = {1'b0, s_r.dband};
      pwm_steer_pkg::ADDR_STEER:  rd_val = {4'h0, s_r.steer};
      pwm_steer_pkg::ADDR_TBASE:  rd_val = s_r.tmr;
      pwm_steer_pkg::ADDR_SHADOW: rd_val = s_r.shadow[DUTY_W-1:DUTY_W-DW];
      pwm_steer_pkg::ADDR_STATUS: rd_val = {4'h0, s_r.shadow[1:0], s_r.mod, s_r.started};
      default:                    rd_val = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdata = reg_rd_in ? rd_val : '0;
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        pwm_steer_pkg::ADDR_CTRL:   s_nxt.ctrl = reg_wdata_in;
        pwm_steer_pkg::ADDR_DUTY:   s_nxt.duty_hi = reg_wdata_in;
        pwm_steer_pkg::ADDR_PERIOD: s_nxt.period = reg_wdata_in;
        pwm_steer_pkg::ADDR_DBAND:  s_nxt.dband = reg_wdata_in[pwm_steer_pkg::DBAND_W-1:0];
        pwm_steer_pkg::ADDR_STEER:  s_nxt.steer = reg_wdata_in[NP-1:0];
        default:                    s_nxt.ctrl = s_r.ctrl;
      endcase
    end

    if (!pwm_on)
    begin
      // leaving modulator mode (incl. an all-zero control) drops the start
      s_nxt.tmr = '0;
      s_nxt.fine = '0;
      s_nxt.mod = 1'b0;
      s_nxt.started = 1'b0;
    end
    else if (pstart)
    begin
      s_nxt.tmr = '0;
      s_nxt.fine = '0;
      s_nxt.shadow = duty_new;
      s_nxt.mod = (duty_new != '0);
      s_nxt.started = 1'b1;
    end
    else
    begin
      s_nxt.tmr = tbase_inc[DUTY_W-1:pwm_steer_pkg::FINE_W];
      s_nxt.fine = tbase_inc[pwm_steer_pkg::FINE_W-1:0];
      // a duty beyond the period never matches, so the output stays set
      if (tbase_inc == s_r.shadow)
        s_nxt.mod = 1'b0;
    end

    if (run)
    begin
      s_nxt.lvl = (act & use_mask) ^ pol_mask;
      s_nxt.oe = use_mask;
    end
    else
    begin
      s_nxt.lvl = '0;
      s_nxt.oe = '0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      s_r <= '{ctrl:    pwm_steer_pkg::RST_CTRL,
               duty_hi: pwm_steer_pkg::RST_DUTY,
               period:  pwm_steer_pkg::RST_PERIOD,
               dband:   pwm_steer_pkg::RST_DBAND,
               steer:   pwm_steer_pkg::RST_STEER,
               tmr:     '0,
               fine:    '0,
               shadow:  '0,
               mod:     1'b0,
               started: 1'b0,
               rdata:   '0,
               lvl:     '0,
               oe:      '0};
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // level and enable leave one register stage, so a pin never shows a level before its enable
  assign reg_rdata_out = s_r.rdata;
  assign out_a_out     = s_r.lvl[pwm_steer_pkg::PIN_A];
  assign out_b_out     = s_r.lvl[pwm_steer_pkg::PIN_B];
  assign out_c_out     = s_r.lvl[pwm_steer_pkg::PIN_C];
  assign out_d_out     = s_r.lvl[pwm_steer_pkg::PIN_D];
  assign out_a_oe_out  = s_r.oe[pwm_steer_pkg::PIN_A];
  assign out_b_oe_out  = s_r.oe[pwm_steer_pkg::PIN_B];
  assign out_c_oe_out  = s_r.oe[pwm_steer_pkg::PIN_C];
  assign out_d_oe_out  = s_r.oe[pwm_steer_pkg::PIN_D];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  release_zero_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (s_r.ctrl == '0) |=> (s_r.oe == '0))
    else $error("pins driven with control register cleared");

  hold_start_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (!s_r.started) |=> (s_r.oe == '0))
    else $error("pins driven before first period start");

  tbase_wrap_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    pstart |=> (s_r.tmr == '0 && s_r.fine == '0 && s_r.started && s_r.mod == ($past(duty_new) != '0)))
    else $error("period end did not restart time base");

  duty_latch_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (pwm_on && !pstart) |=> (s_r.shadow == $past(s_r.shadow)))
    else $error("duty shadow changed inside a period");

  duty_match_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (pwm_on && !pstart && tbase_inc == s_r.shadow) |=> !s_r.mod)
    else $error("output not cleared at duty match");

  single_steer_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (run && cfg == pwm_steer_pkg::CFG_SINGLE) |=>
      (s_r.oe == $past(s_r.steer) && out_a_out == ($past(s_r.mod && s_r.steer[0]) ^ $past(pol_ac))))
    else $error("single mode steering wrong");

  half_pins_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (run && cfg == pwm_steer_pkg::CFG_HALF) |=> (s_r.oe == pwm_steer_pkg::HALF_USE))
    else $error("half-bridge drives wrong pins");

  fwd_levels_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (run && cfg == pwm_steer_pkg::CFG_FWD) |=>
      (out_a_out == !$past(pol_ac) && out_b_out == $past(pol_bd) && out_c_out == $past(pol_ac)
       && out_d_out == ($past(s_r.mod) ^ $past(pol_bd))))
    else $error("forward bridge levels wrong");

  rev_levels_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (run && cfg == pwm_steer_pkg::CFG_REV) |=>
      (out_c_out == !$past(pol_ac) && out_a_out == $past(pol_ac) && out_d_out == $past(pol_bd)
       && out_b_out == ($past(s_r.mod) ^ $past(pol_bd))))
    else $error("reverse bridge levels wrong");

  half_levels_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (run && cfg == pwm_steer_pkg::CFG_HALF) |=>
      (out_a_out == ($past(dly_a) ^ $past(pol_ac)) && out_b_out == ($past(dly_b) ^ $past(pol_bd))))
    else $error("half-bridge levels do not follow the delayed pair");

  // both delayed outputs active at once would let both switches of a leg conduct
  half_overlap_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    !(dly_a && dly_b))
    else $error("both half-bridge outputs active together");

  tbase_step_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (pwm_on && !pstart) |=> (tbase == $past(tbase_inc)))
    else $error("time base did not advance by one");

  mode_off_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (!pwm_on) |=> (!s_r.started && !s_r.mod && tbase == '0))
    else $error("time base kept running with the modulator off");

  full_pins_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (run && (cfg == pwm_steer_pkg::CFG_FWD || cfg == pwm_steer_pkg::CFG_REV)) |=>
      (s_r.oe == pwm_steer_pkg::FULL_USE))
    else $error("full bridge does not drive all four pins");

endmodule

/* File: switch_driver_model.sv */
// external power switch drivers seen through the port pins, with pull-downs on every pad
`timescale 1ns/10ps
module switch_driver_model
(
  input  wire logic [3:0] level_in,
  input  wire logic [3:0] oe_in,
  input  wire logic [3:0] dir_n_in,
  output logic      [3:0] pad_out
);
  // a pad follows the modulator only while it drives and its direction bit is cleared
  // otherwise the pull-down holds the switch off
  assign pad_out = level_in & oe_in & ~dir_n_in;
endmodule

/* File: bridge_pwm_output_steering_bench.sv */
// self-checking testbench of the bridge output steering stage
`timescale 1ns/10ps
module bridge_pwm_output_steering_bench;
  logic                               clk_sys_in = 1'b0;
  logic                               arst_n_in = 1'b0;
  logic [pwm_steer_pkg::ADDR_W-1:0]   reg_addr_in = '0;
  logic [pwm_steer_pkg::DATA_W-1:0]   reg_wdata_in = '0;
  logic                               reg_wr_in = 1'b0;
  logic                               reg_rd_in = 1'b0;
  logic [pwm_steer_pkg::DATA_W-1:0]   reg_rdata_out;
  logic                               out_a_out, out_b_out, out_c_out, out_d_out;
  logic                               out_a_oe_out, out_b_oe_out, out_c_oe_out, out_d_oe_out;
  logic [3:0]                         dir_n = 4'hF;
  logic [3:0]                         pad;
  logic [3:0]                         oe_vec;
  logic [3:0]                         lvl_vec;
  int                                 err_count = 0;
  int                                 tests_run = 0;
  int                                 cnt [4];

  assign oe_vec = {out_d_oe_out, out_c_oe_out, out_b_oe_out, out_a_oe_out};
  assign lvl_vec = {out_d_out, out_c_out, out_b_out, out_a_out};

  always #10 clk_sys_in = ~clk_sys_in;

  bridge_pwm_output_steering u_dut
  (
    .clk_sys_in    (clk_sys_in),
    .arst_n_in     (arst_n_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_wr_in     (reg_wr_in),
    .reg_rd_in     (reg_rd_in),
    .reg_rdata_out (reg_rdata_out),
    .out_a_out     (out_a_out),
    .out_a_oe_out  (out_a_oe_out),
    .out_b_out     (out_b_out),
    .out_b_oe_out  (out_b_oe_out),
    .out_c_out     (out_c_out),
    .out_c_oe_out  (out_c_oe_out),
    .out_d_out     (out_d_out),
    .out_d_oe_out  (out_d_oe_out)
  );

  switch_driver_model u_drivers
  (
    .level_in (lvl_vec),
    .oe_in    (oe_vec),
    .dir_n_in (dir_n),
    .pad_out  (pad)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask

  // counts the cycles each pad is high over n cycles
  task automatic meas(input int n);
    for (int p = 0; p < 4; p++)
      cnt[p] = 0;
    repeat (n)
    begin
      @(posedge clk_sys_in);
      #1;
      for (int p = 0; p < 4; p++)
        cnt[p] += int'(pad[p]);
    end
  endtask

  // re-arms from released pins so every run starts on a fresh period
  task automatic run(input logic [1:0] cfg, input logic [1:0] lsb, input logic [1:0] pol);
    int w;
    wr(pwm_steer_pkg::ADDR_CTRL, 8'h00);
    wr(pwm_steer_pkg::ADDR_CTRL, {cfg, lsb, pwm_steer_pkg::MSEL_PWM, pol});
    // half a period in, the first period has not started, so the pins must still be free
    repeat (8) @(posedge clk_sys_in);
    #1;
    chk(oe_vec, 4'h0);
    w = 0;
    while (oe_vec === 4'h0 && w < 100)
    begin
      @(posedge clk_sys_in);
      #1;
      w++;
    end
    repeat (40) @(posedge clk_sys_in);
    meas(32);
  endtask

  task automatic expect_pads(input int ea, input int eb, input int ec, input int ed);
    chk(cnt[0], ea);
    chk(cnt[1], eb);
    chk(cnt[2], ec);
    chk(cnt[3], ed);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] v;
    rd(pwm_steer_pkg::ADDR_CTRL, v);
    chk(v, pwm_steer_pkg::RST_CTRL);
    rd(pwm_steer_pkg::ADDR_DUTY, v);
    chk(v, pwm_steer_pkg::RST_DUTY);
    rd(pwm_steer_pkg::ADDR_PERIOD, v);
    chk(v, pwm_steer_pkg::RST_PERIOD);
    rd(pwm_steer_pkg::ADDR_DBAND, v);
    chk(v, pwm_steer_pkg::RST_DBAND);
    rd(pwm_steer_pkg::ADDR_STEER, v);
    chk(v, pwm_steer_pkg::RST_STEER);
    chk(oe_vec, 4'h0);
    $display("test reset done");
  endtask

  // period 16 clocks, duty 5 uses the two low duty bits
  task automatic t_single;
    dir_n = 4'h0;
    wr(pwm_steer_pkg::ADDR_PERIOD, 8'h03);
    wr(pwm_steer_pkg::ADDR_DUTY, 8'h01);
    wr(pwm_steer_pkg::ADDR_STEER, 8'h05);
    run(pwm_steer_pkg::CFG_SINGLE, 2'h1, 2'h0);
    chk(oe_vec, 4'h5);
    expect_pads(10, 0, 10, 0);
    run(pwm_steer_pkg::CFG_SINGLE, 2'h1, 2'h3);
    expect_pads(22, 0, 22, 0);
    $display("test single done");
  endtask

  task automatic t_full;
    run(pwm_steer_pkg::CFG_FWD, 2'h1, 2'h0);
    chk(oe_vec, 4'hF);
    expect_pads(32, 0, 0, 10);
    run(pwm_steer_pkg::CFG_FWD, 2'h1, 2'h3);
    expect_pads(0, 32, 32, 22);
    run(pwm_steer_pkg::CFG_REV, 2'h1, 2'h0);
    chk(oe_vec, 4'hF);
    expect_pads(0, 10, 32, 0);
    run(pwm_steer_pkg::CFG_REV, 2'h1, 2'h3);
    expect_pads(32, 22, 0, 32);
    $display("test full bridge done");
  endtask

  // duty 8 of 16; a dead-band unit is four clocks
  task automatic t_half;
    wr(pwm_steer_pkg::ADDR_DUTY, 8'h02);
    wr(pwm_steer_pkg::ADDR_DBAND, 8'h00);
    run(pwm_steer_pkg::CFG_HALF, 2'h0, 2'h0);
    chk(oe_vec, 4'h3);
    expect_pads(16, 16, 0, 0);
    wr(pwm_steer_pkg::ADDR_DBAND, 8'h01);
    run(pwm_steer_pkg::CFG_HALF, 2'h0, 2'h0);
    expect_pads(8, 8, 0, 0);
    wr(pwm_steer_pkg::ADDR_DBAND, 8'h03);
    run(pwm_steer_pkg::CFG_HALF, 2'h0, 2'h0);
    expect_pads(0, 0, 0, 0);
    wr(pwm_steer_pkg::ADDR_CTRL, 8'h00);
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk(oe_vec, 4'h0);
    $display("test half bridge done");
  endtask

  // a duty written just after a period starts must not stretch that period's pulse
  task automatic t_buffer;
    int w;
    logic [7:0] v;
    wr(pwm_steer_pkg::ADDR_DUTY, 8'h01);
    run(pwm_steer_pkg::CFG_SINGLE, 2'h1, 2'h0);
    w = 0;
    while (pad[0] !== 1'b0 && w < 40)
    begin
      @(posedge clk_sys_in);
      #1;
      w++;
    end
    while (pad[0] !== 1'b1 && w < 80)
    begin
      @(posedge clk_sys_in);
      #1;
      w++;
    end
    wr(pwm_steer_pkg::ADDR_DUTY, 8'h03);
    meas(8);
    chk(cnt[0] < 5, 1'b1);
    // the shadow keeps the old duty until the period ends, then takes the new one
    rd(pwm_steer_pkg::ADDR_SHADOW, v);
    chk(v, 8'h01);
    repeat (4) @(posedge clk_sys_in);
    rd(pwm_steer_pkg::ADDR_SHADOW, v);
    chk(v, 8'h03);
    $display("test double buffer done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_single();
    t_full();
    t_half();
    t_buffer();
    final_report();
  end

  // the full sequence needs well under ten thousand cycles
  initial
  begin
    #400000;
    err_count++;
    final_report();
  end
endmodule
